// ===== core/fpx_pkg.sv
// shared constants, types and helpers of the fp exception unit
package fpx_pkg;

  localparam int AW = 8;

  localparam logic [7:0] ADDR_FEAT = 8'h00;
  localparam logic [7:0] ADDR_CTRL = 8'h04;
  localparam logic [7:0] ADDR_EXCS = 8'h08;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // arch_feature_mask_query bit that reports precise fp exceptions
  localparam int          FEAT_PRECISE = 9;
  localparam logic [31:0] FEAT_WORD    = 32'h0000_0001 << FEAT_PRECISE;

  // fp_control_register fields
  localparam int CTRL_DNZ  = 0;
  localparam int CTRL_UNDERFLOW_TO_ZERO_BIT = 1;
  localparam int CTRL_DIS  = 2;
  localparam int CTRL_STS  = 8;

  // exception bit order: status, disables, summary and result flags
  localparam int EX_INV  = 0;
  localparam int EX_DZE  = 1;
  localparam int EX_OVF  = 2;
  localparam int EX_UNF  = 3;
  localparam int EX_INE  = 4;
  localparam int EXS_DEN = 5;

  localparam logic [10:0] EXP_ONES  = 11'h7FF;
  localparam logic [63:0] QBIT_MASK = 64'h0008_0000_0000_0000;

  typedef enum logic [3:0] {
    OP_ADD   = 4'h0,
    OP_SUB   = 4'h1,
    OP_MUL   = 4'h2,
    OP_DIV   = 4'h3,
    OP_SQRT  = 4'h4,
    OP_CMPEQ = 4'h5,
    OP_CMPUN = 4'h6,
    OP_CMPLT = 4'h7,
    OP_CMPLE = 4'h8,
    OP_CVTFF = 4'h9,
    OP_NARTH = 4'hA,
    OP_VSQRT = 4'hB,
    OP_TRAP_BARRIER_OP = 4'hC
  } fpx_op_e;

  typedef enum logic [2:0] {
    CL_ZERO = 3'h0,
    CL_NORM = 3'h1,
    CL_DEN  = 3'h2,
    CL_INF  = 3'h3,
    CL_QNAN = 3'h4,
    CL_SNAN = 3'h5
  } fpx_cls_e;

  // flush turns a denormal into a zero of the same sign
  function automatic fpx_cls_e fpx_class(input logic [63:0] v, input logic flush);
    fpx_cls_e c;
    c = CL_NORM;
    if (v[62:52] == EXP_ONES) begin
      if (v[51:0] == 52'h0) c = CL_INF;
      else if (v[51]) c = CL_QNAN;
      else c = CL_SNAN;
    end else if (v[62:52] == 11'h000) begin
      if (v[51:0] == 52'h0 || flush) c = CL_ZERO;
      else c = CL_DEN;
    end
    return c;
  endfunction

  function automatic logic [63:0] fpx_inf(input logic sgn);
    return {sgn, EXP_ONES, 52'h0};
  endfunction

endpackage

// ===== core/fpx_unit.sv
// fp exception unit: special operands, trap decision, control and summary registers
//
// Our own choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module fpx_unit #(
  parameter logic [63:0] CANON_QNAN = 64'hFFF8_0000_0000_0000,
  parameter logic [63:0] CMP_TRUE   = 64'h4000_0000_0000_0000
) (
  input  wire  logic                   aclk,
  input  wire  logic                   aresetn,
  input  wire  logic [fpx_pkg::AW-1:0] awaddr,
  input  wire  logic                   awvalid,
  output logic                         awready,
  input  wire  logic [31:0]            wdata,
  input  wire  logic [3:0]             wstrb,
  input  wire  logic                   wvalid,
  output logic                         wready,
  output logic [1:0]                   bresp,
  output logic                         bvalid,
  input  wire  logic                   bready,
  input  wire  logic [fpx_pkg::AW-1:0] araddr,
  input  wire  logic                   arvalid,
  output logic                         arready,
  output logic [31:0]                  rdata,
  output logic [1:0]                   rresp,
  output logic                         rvalid,
  input  wire  logic                   rready,
  input  wire  logic                   op_valid,
  input  wire  fpx_pkg::fpx_op_e       op_kind,
  input  wire  logic                   op_sw,
  input  wire  logic                   op_uen,
  input  wire  logic                   op_ien,
  input  wire  logic [63:0]            op_a,
  input  wire  logic [63:0]            op_b,
  input  wire  logic [63:0]            dp_result,
  input  wire  logic                   dp_ovf,
  input  wire  logic                   dp_unf,
  input  wire  logic                   dp_ine,
  input  wire  logic                   dp_cmp,
  output logic                         res_valid,
  output logic [63:0]                  res_data,
  output logic [4:0]                   res_exc,
  output logic                         arith_trap,
  output logic                         denorm_trap
);
  import fpx_pkg::*;

  typedef struct packed {
    logic        awh;
    logic [7:0]  awa;
    logic        wh;
    logic [31:0] wd;
    logic [3:0]  ws;
    logic        awr;
    logic        wr;
    logic        bv;
    logic [1:0]  br;
    logic        arr;
    logic        rv;
    logic [31:0] rd;
    logic [1:0]  rr;
    logic        denormal_to_zero_bit;
    logic        underflow_to_zero_bit;
    logic [4:0]  dis;
    logic [4:0]  sts;
    logic [5:0]  exs;
    logic        rval;
    logic [63:0] res;
    logic [4:0]  rexc;
    logic        trap;
    logic        dtrap;
  } fpx_st_s;

  fpx_st_s s, n;

  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) r[8*i +: 8] = nw[8*i +: 8];
    end
    return r;
  endfunction

  logic        flush_c;
  fpx_cls_e    ca;
  fpx_cls_e    cb;
  logic        bin_op;
  logic        arith;
  logic        a_nan;
  logic        b_nan;
  logic        any_snan;
  logic        has_dn;
  logic        dtrap_c;
  logic        commit;
  logic        wr_go;
  logic        ctrl_we;
  logic [31:0] ctrl_word;
  logic [63:0] nan_res;
  logic        sx;
  logic        effsub;
  logic        spec;
  logic [63:0] r_c;
  logic [4:0]  exc_c;
  logic [4:0]  en_c;
  logic [4:0]  trapbits;
  logic [31:0] cw;

  // denormals become zero only for software-completion ops with the flush bit set
  assign flush_c  = s.denormal_to_zero_bit & op_sw;
  assign ca       = fpx_class(op_a, flush_c);
  assign cb       = fpx_class(op_b, flush_c);
  assign bin_op   = op_kind inside {OP_ADD, OP_SUB, OP_MUL, OP_DIV, OP_CMPEQ, OP_CMPUN, OP_CMPLT, OP_CMPLE};
  // sign copies, conditional moves, control moves and vax roots are not IEEE arithmetic
  assign arith    = bin_op | (op_kind inside {OP_SQRT, OP_CVTFF});
  assign a_nan    = bin_op & (ca == CL_QNAN || ca == CL_SNAN);
  assign b_nan    = cb == CL_QNAN || cb == CL_SNAN;
  assign any_snan = (bin_op & ca == CL_SNAN) | (cb == CL_SNAN);
  assign has_dn   = arith & ((bin_op & fpx_class(op_a, 1'b0) == CL_DEN) | (fpx_class(op_b, 1'b0) == CL_DEN));
  assign dtrap_c  = has_dn & ~flush_c;
  assign commit   = op_valid & (op_kind != OP_TRAP_BARRIER_OP);
  assign nan_res  = (a_nan ? op_a : op_b) | QBIT_MASK;
  assign sx       = op_a[63] ^ op_b[63];
  assign effsub   = sx ^ (op_kind == OP_SUB);
  assign wr_go    = s.awh & s.wh & ~s.bv;
  assign ctrl_we  = wr_go & (s.awa == ADDR_CTRL);
  assign ctrl_word = {19'h0, s.sts, 1'b0, s.dis, s.underflow_to_zero_bit, s.denormal_to_zero_bit};
  // underflow and inexact trap only when the instruction enables them
  assign en_c     = {op_ien, op_uen, 3'b111};

  always_comb begin
    n     = s;
    spec  = 1'b1;
    r_c   = dp_result;
    exc_c = 5'h00;
    cw    = 32'h0000_0000;
    // input operand conditions first; they decide the result outright
    case (op_kind)
      OP_ADD, OP_SUB, OP_MUL: begin
        if (a_nan || b_nan) begin
          r_c = nan_res;
          exc_c[EX_INV] = any_snan;
        end else if (op_kind != OP_MUL && ca == CL_INF && cb == CL_INF && effsub) begin
          r_c = CANON_QNAN;
          exc_c[EX_INV] = 1'b1;
        end else if (op_kind == OP_MUL && ((ca == CL_INF && cb == CL_ZERO) || (ca == CL_ZERO && cb == CL_INF))) begin
          r_c = CANON_QNAN;
          exc_c[EX_INV] = 1'b1;
        end else if (op_kind == OP_MUL && (ca == CL_INF || cb == CL_INF)) begin
          r_c = fpx_inf(sx);
        end else if (ca == CL_INF) begin
          r_c = fpx_inf(op_a[63]);
        end else if (cb == CL_INF) begin
          r_c = fpx_inf(op_b[63] ^ (op_kind == OP_SUB));
        end else begin
          spec = 1'b0;
        end
      end
      OP_DIV: begin
        if (a_nan || b_nan) begin
          r_c = nan_res;
          exc_c[EX_INV] = any_snan;
        end else if ((ca == CL_ZERO && cb == CL_ZERO) || (ca == CL_INF && cb == CL_INF)) begin
          r_c = CANON_QNAN;
          exc_c[EX_INV] = 1'b1;
        end else if (cb == CL_ZERO) begin
          r_c = fpx_inf(sx);
          exc_c[EX_DZE] = 1'b1;
        end else if (cb == CL_INF) begin
          r_c = {sx, 63'h0};
        end else if (ca == CL_INF) begin
          r_c = fpx_inf(sx);
        end else begin
          spec = 1'b0;
        end
      end
      OP_SQRT: begin
        if (b_nan) begin
          r_c = nan_res;
          exc_c[EX_INV] = any_snan;
        end else if (cb == CL_ZERO) begin
          r_c = {op_b[63], 63'h0};
        end else if (op_b[63]) begin
          r_c = CANON_QNAN;
          exc_c[EX_INV] = 1'b1;
        end else if (cb == CL_INF) begin
          r_c = fpx_inf(1'b0);
        end else begin
          spec = 1'b0;
        end
      end
      OP_CVTFF: begin
        if (b_nan) begin
          r_c = nan_res;
          exc_c[EX_INV] = any_snan;
        end else if (cb == CL_INF) begin
          r_c = fpx_inf(op_b[63]);
        end else begin
          spec = 1'b0;
        end
      end
      OP_CMPEQ, OP_CMPUN, OP_CMPLT, OP_CMPLE: begin
        if (a_nan || b_nan) begin
          r_c = (op_kind == OP_CMPUN) ? CMP_TRUE : 64'h0;
          exc_c[EX_INV] = (op_kind inside {OP_CMPLT, OP_CMPLE}) ? 1'b1 : any_snan;
        end else begin
          r_c = (op_kind == OP_CMPUN) ? 64'h0 : (dp_cmp ? CMP_TRUE : 64'h0);
        end
      end
      default: begin
        // vax roots and non-arithmetic moves take the datapath value as is
        r_c = dp_result;
      end
    endcase
    // result conditions only when no input condition decided the result
    if (!spec && op_kind inside {OP_ADD, OP_SUB, OP_MUL, OP_DIV, OP_CVTFF}) begin
      exc_c[EX_OVF] = dp_ovf;
      exc_c[EX_UNF] = dp_unf;
      exc_c[EX_INE] = dp_ine;
      if (dp_unf) r_c = 64'h0;
      else if (dp_ovf) r_c = fpx_inf(dp_result[63]);
    end else if (!spec && op_kind == OP_SQRT) begin
      exc_c[EX_INE] = dp_ine;
    end
    trapbits = exc_c & en_c & ~(op_sw ? s.dis : 5'h00);

    // register bus, write side
    if (awvalid && s.awr) begin
      n.awh = 1'b1;
      n.awa = awaddr;
    end
    if (wvalid && s.wr) begin
      n.wh = 1'b1;
      n.wd = wdata;
      n.ws = wstrb;
    end
    if (s.bv && bready) n.bv = 1'b0;
    if (wr_go) begin
      n.awh = 1'b0;
      n.wh  = 1'b0;
      n.bv  = 1'b1;
      n.br  = RESP_OKAY;
      if (s.awa == ADDR_CTRL) begin
        cw     = wmerge(ctrl_word, s.wd, s.ws);
        n.denormal_to_zero_bit  = cw[CTRL_DNZ];
        n.underflow_to_zero_bit = cw[CTRL_UNDERFLOW_TO_ZERO_BIT];
        n.dis  = cw[CTRL_DIS +: 5];
        n.sts  = cw[CTRL_STS +: 5];
      end else if (s.awa == ADDR_EXCS) begin
        cw    = wmerge(32'h0000_0000, s.wd, s.ws);
        n.exs = s.exs & ~cw[5:0];
      end else if (s.awa != ADDR_FEAT) begin
        n.br = RESP_SLVERR;
      end
    end
    n.awr = ~n.awh;
    n.wr  = ~n.wh;

    // register bus, read side
    if (s.rv && rready) n.rv = 1'b0;
    if (arvalid && s.arr) begin
      n.rv = 1'b1;
      n.rr = RESP_OKAY;
      if (araddr == ADDR_FEAT) n.rd = FEAT_WORD;
      else if (araddr == ADDR_CTRL) n.rd = ctrl_word;
      else if (araddr == ADDR_EXCS) n.rd = {26'h0, s.exs};
      else begin
        n.rd = 32'h0000_0000;
        n.rr = RESP_SLVERR;
      end
    end
    n.arr = ~n.rv;

    // commit: events are ORed after the bus write so a set beats a clear
    n.rval  = commit;
    n.trap  = 1'b0;
    n.dtrap = 1'b0;
    if (commit) begin
      n.res  = r_c;
      n.rexc = exc_c;
      n.sts  = n.sts | exc_c;
      if (dtrap_c) begin
        n.dtrap        = 1'b1;
        n.exs[EXS_DEN] = 1'b1;
      end else if (trapbits != 5'h00) begin
        n.trap     = 1'b1;
        n.exs[4:0] = n.exs[4:0] | trapbits;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) s <= '0;
    else s <= n;
  end

  assign awready     = s.awr;
  assign wready      = s.wr;
  assign bvalid      = s.bv;
  assign bresp       = s.br;
  assign arready     = s.arr;
  assign rvalid      = s.rv;
  assign rdata       = s.rd;
  assign rresp       = s.rr;
  assign res_valid   = s.rval;
  assign res_data    = s.res;
  assign res_exc     = s.rexc;
  assign arith_trap  = s.trap;
  assign denorm_trap = s.dtrap;

  default clocking cb_clk @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_feat_precise: assert property (
    arvalid && arready && araddr == ADDR_FEAT |=> rvalid && rdata[FEAT_PRECISE])
    else $error("feature mask lacks precise bit");
  a_barrier_nop: assert property (
    op_valid && op_kind == OP_TRAP_BARRIER_OP |=> !res_valid && !arith_trap && !denorm_trap)
    else $error("trap barrier was issued");
  a_qnan_pass: assert property (
    op_valid && op_kind == OP_ADD && ca == CL_QNAN && cb != CL_SNAN |=> res_data == $past(op_a) && res_exc == 5'h00)
    else $error("quiet nan not propagated");
  a_inf_add: assert property (
    op_valid && op_kind == OP_ADD && ca == CL_INF && cb == CL_NORM |=> res_data == fpx_inf($past(op_a[63])))
    else $error("infinity add wrong");
  a_denorm_first: assert property (
    op_valid && arith && has_dn && !flush_c |=> denorm_trap && !arith_trap && s.exs[EXS_DEN])
    else $error("denormal trap missing");
  a_disable_supp: assert property (
    op_valid && op_sw && !dtrap_c && (exc_c & en_c & ~s.dis) == 5'h00 |=> !arith_trap)
    else $error("disabled exception trapped");
  a_unf_zero: assert property (
    res_valid && res_exc[EX_UNF] |-> res_data == 64'h0)
    else $error("underflow result not +0");
  a_sts_record: assert property (
    res_valid |-> (s.sts & res_exc) == res_exc)
    else $error("status missed an exception");
  a_sts_hold: assert property (
    !ctrl_we |=> (s.sts & $past(s.sts)) == $past(s.sts))
    else $error("status cleared without write");
  a_trap_logged: assert property (
    commit && !dtrap_c && trapbits != 5'h00 |=> arith_trap && (s.exs[4:0] & res_exc) != 5'h00)
    else $error("enabled exception not trapped");
  a_sqrt_neg: assert property (
    op_valid && op_kind == OP_SQRT && cb == CL_NORM && op_b[63] |=> res_data == CANON_QNAN && res_exc[EX_INV])
    else $error("negative root wrong");
  a_cmp_unord: assert property (
    op_valid && op_kind == OP_CMPUN && (a_nan || b_nan) ##1 res_valid |-> res_data == CMP_TRUE)
    else $error("unordered compare wrong");

endmodule
`default_nettype wire

// ===== test/fpx_unit_tb_top.sv
// self-checking bench of the fp exception unit
`timescale 1ns/1ns
`default_nettype none
module fpx_unit_tb_top;
  import fpx_pkg::*;
  localparam logic [63:0] CQN   = 64'hFFF8_0000_0000_0000;
  localparam logic [63:0] CTRUE = 64'h4000_0000_0000_0000;
  localparam logic [63:0] PINF  = 64'h7FF0_0000_0000_0000;
  localparam logic [63:0] NINF  = 64'hFFF0_0000_0000_0000;
  localparam logic [63:0] ONE   = 64'h3FF0_0000_0000_0000;
  localparam logic [63:0] NM    = 64'hFFEF_FFFF_FFFF_FFFF;
  localparam logic [63:0] DEN   = 64'h0000_0000_0000_0001;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        op_valid, op_sw, op_uen, op_ien, dp_ovf, dp_unf, dp_ine, dp_cmp;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, ctrl_m;
  logic [3:0]  wstrb;
  fpx_op_e     op_kind;
  logic [63:0] op_a, op_b, dp_result, rn, qn, sn;
  logic [71:0] e;
  wire logic   awready, wready, bvalid, arready, rvalid, res_valid, arith_trap, denorm_trap;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [63:0] res_data;
  wire logic [4:0]  res_exc;
  int          n_mismatch, compares;
  logic [1:0]  q_b[$];
  logic [33:0] q_r[$];
  logic [71:0] q_op[$];

  fpx_unit #(.CANON_QNAN(CQN), .CMP_TRUE(CTRUE)) fpx_unit_i (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .op_valid(op_valid), .op_kind(op_kind),
    .op_sw(op_sw), .op_uen(op_uen), .op_ien(op_ien), .op_a(op_a), .op_b(op_b),
    .dp_result(dp_result), .dp_ovf(dp_ovf), .dp_unf(dp_unf), .dp_ine(dp_ine), .dp_cmp(dp_cmp),
    .res_valid(res_valid), .res_data(res_data), .res_exc(res_exc), .arith_trap(arith_trap),
    .denorm_trap(denorm_trap));

  initial begin
    aclk = 0;
    forever #5 aclk = ~aclk;
  end

  task automatic final_report;
    $display("mismatches %0d comparisons %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bus(input logic [33:0] got, input logic [33:0] exp);
    chk(64'(got), 64'(exp));
  endtask

  task automatic chk_flag(input logic got, input logic exp);
    chk(64'(got), 64'(exp));
  endtask

  task automatic tmo(inout int n);
    n++;
    if (n > 100) begin
      n_mismatch++;
      final_report();
    end
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    bit ad, wd;
    int n;
    ad = 0;
    wd = 0;
    n = 0;
    q_b.push_back(er);
    if (a == ADDR_CTRL) ctrl_m = d;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(posedge aclk);
      tmo(n);
      if (!ad && awready) begin
        ad = 1;
        awvalid <= 0;
      end
      if (!wd && wready) begin
        wd = 1;
        wvalid <= 0;
      end
    end while (bvalid !== 1'b1);
    bready <= 0;
  endtask

  task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    bit ad;
    int n;
    ad = 0;
    n = 0;
    q_r.push_back({er, ed});
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do begin
      @(posedge aclk);
      tmo(n);
      if (!ad && arready) begin
        ad = 1;
        arvalid <= 0;
      end
    end while (rvalid !== 1'b1);
    rready <= 0;
  endtask

  // fl = {cmp, ine, unf, ovf}, q = {ien, uen, sw}; den marks a trap-eligible denormal input
  task automatic op(input fpx_op_e k, input logic [63:0] a, b, r, input logic [3:0] fl,
                    input logic [2:0] q, input logic [63:0] ed, input logic [4:0] ee, input logic den, dc);
    logic dt, tr;
    dt = den && !(ctrl_m[CTRL_DNZ] && q[0]);
    tr = !dt && |(ee & {q[2], q[1], 3'b111} & ~(q[0] ? ctrl_m[CTRL_DIS +: 5] : 5'h00));
    if (k != OP_TRAP_BARRIER_OP) q_op.push_back({dc, tr, dt, ee, ed});
    @(posedge aclk);
    op_valid <= 1;
    op_kind <= k;
    op_a <= a;
    op_b <= b;
    dp_result <= r;
    {dp_cmp, dp_ine, dp_unf, dp_ovf} <= fl;
    {op_ien, op_uen, op_sw} <= q;
  endtask

  task automatic idle;
    @(posedge aclk);
    op_valid <= 0;
    repeat (2) @(posedge aclk);
  endtask

  // an unexpected result with an empty queue counts as a mismatch, which catches a trap barrier result
  always @(posedge aclk) begin
    if (bvalid === 1'b1 && bready && q_b.size() > 0) chk_bus(34'(bresp), 34'(q_b.pop_front()));
    if (rvalid === 1'b1 && rready && q_r.size() > 0) chk_bus({rresp, rdata}, q_r.pop_front());
    if (res_valid === 1'b1) begin
      if (q_op.size() == 0) chk_flag(1'b1, 1'b0);
      else begin
        e = q_op.pop_front();
        if (!e[71]) chk(res_data, e[63:0]);
        if (!e[71]) chk(64'(res_exc), 64'(e[68:64]));
        chk_flag(arith_trap, e[70]);
        chk_flag(denorm_trap, e[69]);
      end
    end
  end

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, op_valid, op_sw, op_uen, op_ien} = '0;
    {dp_ovf, dp_unf, dp_ine, dp_cmp} = '0;
    {awaddr, araddr, wdata, wstrb, op_a, op_b, dp_result} = '0;
    op_kind = OP_ADD;
    ctrl_m = '0;
    void'($urandom(87));
    rn = {1'b0, 11'h400, 20'($urandom), $urandom};
    repeat (16) @(posedge aclk);
    aresetn <= 1;
    axr(ADDR_FEAT, 32'h0000_0200, RESP_OKAY);
    axr(ADDR_CTRL, 32'h0, RESP_OKAY);
    axr(ADDR_EXCS, 32'h0, RESP_OKAY);
    axr(8'h0C, 32'h0, RESP_SLVERR);
    axw(8'h0C, 32'hFFFF_FFFF, RESP_SLVERR);
    op(OP_DIV, ONE, 64'h0, rn, 4'h0, 3'b000, PINF, 5'h02, 0, 0);
    op(OP_ADD, ONE, ONE, rn, 4'h4, 3'b000, rn, 5'h10, 0, 0);
    idle();
    axr(ADDR_CTRL, 32'h0000_1200, RESP_OKAY);
    axr(ADDR_EXCS, 32'h0000_0002, RESP_OKAY);
    axw(ADDR_EXCS, 32'h0000_0002, RESP_OKAY);
    axr(ADDR_EXCS, 32'h0, RESP_OKAY);
    axr(ADDR_CTRL, 32'h0000_1200, RESP_OKAY);
    axw(ADDR_CTRL, 32'h0, RESP_OKAY);
    axr(ADDR_CTRL, 32'h0, RESP_OKAY);
    // back-to-back random nan payloads
    for (int i = 0; i < 4; i++) begin
      rn = {1'b0, 11'h400, 20'($urandom), $urandom};
      qn = {1'b0, 11'h7FF, 1'b1, 19'($urandom), $urandom};
      sn = {1'b0, 11'h7FF, 1'b0, 18'($urandom), $urandom, 1'b1};
      op(OP_ADD, qn, rn, rn, 4'h0, 3'b000, qn, 5'h00, 0, 0);
      op(OP_MUL, rn, sn, rn, 4'h0, 3'b000, sn | QBIT_MASK, 5'h01, 0, 0);
      op(OP_DIV, qn, rn, rn, 4'h0, 3'b000, qn, 5'h00, 0, 0);
      op(OP_DIV, rn, sn, rn, 4'h0, 3'b000, sn | QBIT_MASK, 5'h01, 0, 0);
      op(OP_SQRT, rn, sn, rn, 4'h0, 3'b000, sn | QBIT_MASK, 5'h01, 0, 0);
      op(OP_CVTFF, rn, sn, rn, 4'h0, 3'b000, sn | QBIT_MASK, 5'h01, 0, 0);
      op(OP_CVTFF, rn, qn, rn, 4'h0, 3'b000, qn, 5'h00, 0, 0);
      op(OP_CVTFF, rn, NINF, rn, 4'h0, 3'b000, NINF, 5'h00, 0, 0);
    end
    op(OP_ADD, PINF, rn, rn, 4'h0, 3'b000, PINF, 5'h00, 0, 0);
    op(OP_MUL, NINF, rn, rn, 4'h0, 3'b000, NINF, 5'h00, 0, 0);
    op(OP_SUB, PINF, PINF, rn, 4'h0, 3'b000, CQN, 5'h01, 0, 0);
    op(OP_ADD, PINF, NINF, rn, 4'h0, 3'b000, CQN, 5'h01, 0, 0);
    op(OP_MUL, 64'h0, NINF, rn, 4'h0, 3'b000, CQN, 5'h01, 0, 0);
    op(OP_ADD, NM, NM, NM, 4'h1, 3'b000, NINF, 5'h04, 0, 0);
    op(OP_MUL, rn, rn, 64'h8000_0000_0000_0001, 4'h2, 3'b000, 64'h0, 5'h08, 0, 0);
    op(OP_MUL, rn, rn, 64'h8000_0000_0000_0001, 4'h2, 3'b010, 64'h0, 5'h08, 0, 0);
    op(OP_ADD, rn, rn, rn, 4'h4, 3'b100, rn, 5'h10, 0, 0);
    op(OP_DIV, 64'hBFF0_0000_0000_0000, 64'h0, rn, 4'h0, 3'b000, NINF, 5'h02, 0, 0);
    op(OP_DIV, 64'h0, 64'h0, rn, 4'h0, 3'b000, CQN, 5'h01, 0, 0);
    op(OP_DIV, PINF, PINF, rn, 4'h0, 3'b000, CQN, 5'h01, 0, 0);
    op(OP_SQRT, rn, PINF, rn, 4'h0, 3'b000, PINF, 5'h00, 0, 0);
    op(OP_SQRT, rn, 64'h8000_0000_0000_0000, rn, 4'h0, 3'b000, 64'h8000_0000_0000_0000, 5'h00, 0, 0);
    op(OP_SQRT, rn, 64'hBFF0_0000_0000_0000, rn, 4'h0, 3'b000, CQN, 5'h01, 0, 0);
    op(OP_SQRT, rn, ONE, rn, 4'h4, 3'b000, rn, 5'h10, 0, 0);
    op(OP_CMPEQ, qn, rn, rn, 4'h0, 3'b000, 64'h0, 5'h00, 0, 0);
    op(OP_CMPUN, qn, rn, rn, 4'h0, 3'b000, CTRUE, 5'h00, 0, 0);
    op(OP_CMPUN, rn, sn, rn, 4'h0, 3'b000, CTRUE, 5'h01, 0, 0);
    op(OP_CMPLT, qn, rn, rn, 4'h0, 3'b000, 64'h0, 5'h01, 0, 0);
    op(OP_CMPLE, rn, sn, rn, 4'h8, 3'b000, 64'h0, 5'h01, 0, 0);
    op(OP_CMPEQ, rn, rn, rn, 4'h8, 3'b000, CTRUE, 5'h00, 0, 0);
    op(OP_NARTH, DEN, DEN, DEN, 4'h0, 3'b000, DEN, 5'h00, 0, 0);
    op(OP_VSQRT, rn, rn, rn, 4'h0, 3'b000, rn, 5'h00, 0, 0);
    op(OP_TRAP_BARRIER_OP, rn, rn, rn, 4'h0, 3'b000, rn, 5'h00, 0, 0);
    op(OP_ADD, DEN, ONE, ONE, 4'h1, 3'b000, ONE, 5'h00, 1, 1);
    idle();
    // denormal-to-zero plus invalid and overflow disables
    axw(ADDR_CTRL, 32'h0000_0015, RESP_OKAY);
    op(OP_MUL, rn, sn, rn, 4'h0, 3'b001, sn | QBIT_MASK, 5'h01, 0, 0);
    op(OP_MUL, rn, sn, rn, 4'h0, 3'b000, sn | QBIT_MASK, 5'h01, 0, 0);
    op(OP_ADD, NM, NM, NM, 4'h1, 3'b001, NINF, 5'h04, 0, 0);
    op(OP_DIV, ONE, DEN, rn, 4'h0, 3'b001, PINF, 5'h02, 1, 0);
    op(OP_DIV, ONE, DEN, rn, 4'h0, 3'b000, rn, 5'h00, 1, 1);
    idle();
    // software pairs the underflow disable with underflow-to-zero
    axw(ADDR_CTRL, 32'h0000_0022, RESP_OKAY);
    op(OP_MUL, rn, rn, 64'h8000_0000_0000_0001, 4'h2, 3'b011, 64'h0, 5'h08, 0, 0);
    idle();
    axr(ADDR_CTRL, 32'h0000_0822, RESP_OKAY);
    repeat (4) @(posedge aclk);
    chk(64'(q_op.size()), 64'h0);
    chk(64'(q_b.size() + q_r.size()), 64'h0);
    final_report();
  end
endmodule
`default_nettype wire
